/* File: core/iopced_top.sv */
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "iopced_map.svh"
module iopced_top
    import iopced_pkg::*;
#(
    parameter int EVT_DEPTH = 64,
    parameter logic [10:0] FASTEST_TENTHS = 11'h004
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic [10:0] cycle_period_tenths,
    output logic [23:0] cycle_period_clocks,
    output logic id_check_en,
    output logic rev_v11,
    output logic offline_cfg_wr,
    output logic ds_backup_en,
    output logic ds_restore_en
);
    localparam int AW = $clog2(EVT_DEPTH);
    localparam logic [23:0] CLK_PER_TENTH = 24'(`IOPCED_PCLK_MHZ * 100);

    initial begin
        if (EVT_DEPTH < 2 || EVT_DEPTH > 64 || (EVT_DEPTH & (EVT_DEPTH - 1)) != 0) begin
            $error("EVT_DEPTH must be a power of two from 2 to 64");
        end
        if (FASTEST_TENTHS < `IOPCED_MIN_TENTHS) begin
            $error("FASTEST_TENTHS below link minimum");
        end
        // the longest period must still fit 24 bits of clocks
        if (32'h00000530 * (`IOPCED_PCLK_MHZ * 100) > 32'h00FFFFFF) begin
            $error("clock count of the longest period exceeds 24 bits");
        end
    end

    // ****************************************
    // event store
    // ****************************************
    // one word per record: descriptor in bits 23:16, event code below
    logic [23:0] evt_mem [EVT_DEPTH];

    // write side of the ring
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] wr_ptr_d;

    // read side of the ring
    logic [AW-1:0] rd_ptr_q;
    logic [AW-1:0] rd_ptr_d;

    // one extra bit tells a full ring from an empty one
    logic [AW:0] count_q;
    logic [AW:0] count_d;

    // head record kept in a flop so a read needs no memory port
    logic [23:0] head_q;
    logic [23:0] head_d;

    logic wr_acc;
    logic rd_acc;
    logic push;
    logic pop;

    // ****************************************
    // registers
    // ****************************************
    // setting registers
    logic [2:0] ctrl_q;
    logic [2:0] ctrl_d;
    logic [7:0] cycle_q;
    logic [7:0] cycle_d;
    logic [10:0] period_q;
    logic [10:0] period_d;

    // period in clocks lags the period in tenths by one cycle
    logic [23:0] clocks_q;
    logic [23:0] clocks_d;

    // status bits: pushed, overflow, reserved base, period changed
    logic [3:0] stat_q;
    logic [3:0] stat_d;
    logic [3:0] mask_q;
    logic [3:0] mask_d;
    logic stat_clr;
    logic irq_d;

    // bus response
    logic [31:0] rdata_d;
    logic ready_q;
    logic err_d;

    // decoded policy: restore, backup, offline write, revision 1.1, identity check
    logic [4:0] pol_d;
    logic [4:0] pol_q;

    // field view of the head descriptor
    logic [31:0] fld_d;

    logic cyc_wr;
    logic rsvd_evt;
    iopced_base_t base;
    logic [5:0] mult;
    logic [10:0] calc;

    // ****************************************
    // bus decode
    // ****************************************
    assign wr_acc = psel && penable && pwrite && !ready_q;
    assign rd_acc = psel && penable && !pwrite && !ready_q;
    assign push = wr_acc && paddr == `IOPCED_OFF_EVT_IN;
    assign pop = wr_acc && paddr == `IOPCED_OFF_EVT_POP && count_q != '0;
    assign cyc_wr = wr_acc && paddr == `IOPCED_OFF_CYCLE;
    assign stat_clr = wr_acc && paddr == `IOPCED_OFF_IRQ_STAT;

    always_comb begin
        wr_ptr_d = wr_ptr_q;
        rd_ptr_d = rd_ptr_q;
        count_d = count_q;
        if (push && count_q != (AW+1)'(EVT_DEPTH)) begin
            wr_ptr_d = wr_ptr_q + 1'b1;
            count_d = count_d + 1'b1;
        end
        if (pop) begin
            rd_ptr_d = rd_ptr_q + 1'b1;
            count_d = count_d - 1'b1;
        end
        head_d = evt_mem[rd_ptr_d];
        if (count_d == '0) begin
            head_d = '0;
        end else if (count_q == '0 || (pop && count_q == 1)) begin
            head_d = pwdata[23:0];
        end
    end

    always_ff @(posedge pclk) begin
        if (push && count_q != (AW+1)'(EVT_DEPTH)) begin
            evt_mem[wr_ptr_q] <= pwdata[23:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
            head_q <= '0;
        end else begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            count_q <= count_d;
            head_q <= head_d;
        end
    end

    // ****************************************
    // cycle period computation
    // ****************************************
    always_comb begin
        base = iopced_base_t'(pwdata[7:`IOPCED_BASE_LSB]);
        mult = pwdata[`IOPCED_MULT_MSB:0];
        unique case (base)
            IOPCED_BASE_100US: begin
                calc = {5'h00, mult};
                if (calc < `IOPCED_MIN_TENTHS) begin
                    calc = `IOPCED_MIN_TENTHS;
                end
            end
            IOPCED_BASE_400US: calc = `IOPCED_B01_OFS_TENTHS + 11'({mult, 2'b00});
            IOPCED_BASE_1600US: calc = `IOPCED_B10_OFS_TENTHS + 11'({mult, 4'h0});
            IOPCED_BASE_RSVD: calc = period_q;
        endcase
        if (pwdata[7:0] == 8'h00) begin
            calc = FASTEST_TENTHS;
        end
        cycle_d = cycle_q;
        period_d = period_q;
        rsvd_evt = 1'b0;
        if (cyc_wr) begin
            if (base == IOPCED_BASE_RSVD) begin
                rsvd_evt = 1'b1;
            end else begin
                cycle_d = pwdata[7:0];
                period_d = calc;
            end
        end
        clocks_d = 24'(period_q * CLK_PER_TENTH);
    end

    // ****************************************
    // validation policy decode
    // ****************************************
    always_comb begin
        pol_d = 5'h00;
        unique case (iopced_valid_t'(ctrl_q))
            IOPCED_VAL_NONE: pol_d = 5'h00;
            IOPCED_VAL_V10: pol_d = 5'b00101;
            IOPCED_VAL_V11: pol_d = 5'b00111;
            IOPCED_VAL_V11_BACKUP: pol_d = 5'b11011;
            IOPCED_VAL_V11_RESTORE: pol_d = 5'b10011;
            default: pol_d = 5'h00;
        endcase
    end

    // ****************************************
    // apb slave and interrupts
    // ****************************************
    always_comb begin
        ctrl_d = ctrl_q;
        mask_d = mask_q;
        err_d = 1'b0;
        rdata_d = '0;
        if (wr_acc) begin
            unique case (paddr)
                `IOPCED_OFF_CTRL: begin
                    if (pwdata[2:0] <= 3'h4) begin
                        ctrl_d = pwdata[2:0];
                    end else begin
                        err_d = 1'b1;
                    end
                end
                `IOPCED_OFF_CYCLE: err_d = rsvd_evt;
                `IOPCED_OFF_EVT_IN, `IOPCED_OFF_EVT_POP, `IOPCED_OFF_IRQ_STAT: ;
                `IOPCED_OFF_IRQ_MASK: mask_d = pwdata[3:0];
                default: err_d = 1'b1;
            endcase
        end
        if (rd_acc) begin
            unique case (paddr)
                `IOPCED_OFF_CTRL: rdata_d = {29'h0, ctrl_q};
                `IOPCED_OFF_CYCLE: rdata_d = {24'h0, cycle_q};
                `IOPCED_OFF_PERIOD: rdata_d = {21'h0, period_q};
                `IOPCED_OFF_EVT_CNT: rdata_d = {25'h0, 7'(count_q)};
                `IOPCED_OFF_EVT_DESC: rdata_d = {8'h00, head_q};
                `IOPCED_OFF_EVT_FLD: rdata_d = fld_d;
                `IOPCED_OFF_POLICY: rdata_d = {27'h0, pol_q};
                `IOPCED_OFF_IRQ_STAT: rdata_d = {28'h0, stat_q};
                `IOPCED_OFF_IRQ_MASK: rdata_d = {28'h0, mask_q};
                default: err_d = 1'b1;
            endcase
        end
    end

    // ****************************************
    // interrupt status
    // ****************************************
    always_comb begin
        stat_d = stat_q;
        if (stat_clr) begin
            stat_d = stat_q & ~pwdata[3:0];
        end
        // set wins over clear
        if (push) begin
            stat_d[0] = 1'b1;
        end
        if (push && count_q == (AW+1)'(EVT_DEPTH)) begin
            stat_d[1] = 1'b1;
        end
        if (rsvd_evt) begin
            stat_d[2] = 1'b1;
        end
        if (cyc_wr && !rsvd_evt) begin
            stat_d[3] = 1'b1;
        end
        irq_d = |(stat_d & mask_d);
    end

    // ****************************************
    // head descriptor field view
    // ****************************************
    always_comb begin
        fld_d = '0;
        fld_d[2:0] = head_q[16+`IOPCED_INST_LSB +: 3];
        fld_d[3] = head_q[16+`IOPCED_INST_LSB +: 3] != 3'h0
            && head_q[16+`IOPCED_INST_LSB +: 3] != `IOPCED_INST_APP;
        fld_d[8] = head_q[16+`IOPCED_SRC_BIT];
        fld_d[17:16] = head_q[16+`IOPCED_TYPE_LSB +: 2];
        fld_d[18] = head_q[16+`IOPCED_TYPE_LSB +: 2] == 2'h0;
        fld_d[25:24] = head_q[16+`IOPCED_MODE_LSB +: 2];
        fld_d[26] = head_q[16+`IOPCED_MODE_LSB +: 2] == 2'h0;
    end

    // ****************************************
    // cycle setting registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cycle_q <= `IOPCED_CYCLE_RST;
            period_q <= FASTEST_TENTHS;
            clocks_q <= '0;
        end else begin
            cycle_q <= cycle_d;
            period_q <= period_d;
            clocks_q <= clocks_d;
        end
    end

    // ****************************************
    // validation policy registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `IOPCED_CTRL_RST;
            pol_q <= '0;
        end else begin
            ctrl_q <= ctrl_d;
            pol_q <= pol_d;
        end
    end

    // ****************************************
    // interrupt registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= '0;
            mask_q <= '0;
            irq <= 1'b0;
        end else begin
            stat_q <= stat_d;
            mask_q <= mask_d;
            irq <= irq_d;
        end
    end

    // ****************************************
    // bus response registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_q <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end else begin
            // one wait state: answer in the second access cycle
            ready_q <= psel && penable && !ready_q;
            prdata <= rdata_d;
            pslverr <= err_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign pready = ready_q;
    assign cycle_period_tenths = period_q;
    assign cycle_period_clocks = clocks_q;
    assign id_check_en = pol_q[0];
    assign rev_v11 = pol_q[1];
    assign offline_cfg_wr = pol_q[2];
    assign ds_backup_en = pol_q[3];
    assign ds_restore_en = pol_q[4];
endmodule : iopced_top

/* File: core/iopced_map.svh */
`ifndef IOPCED_MAP_SVH
`define IOPCED_MAP_SVH
// ****************************************
// register byte offsets
// ****************************************
`define IOPCED_OFF_CTRL 12'h000
`define IOPCED_OFF_CYCLE 12'h004
`define IOPCED_OFF_PERIOD 12'h008
`define IOPCED_OFF_EVT_IN 12'h00C
`define IOPCED_OFF_EVT_CNT 12'h010
`define IOPCED_OFF_EVT_POP 12'h014
`define IOPCED_OFF_EVT_DESC 12'h018
`define IOPCED_OFF_EVT_FLD 12'h01C
`define IOPCED_OFF_POLICY 12'h020
`define IOPCED_OFF_IRQ_STAT 12'h024
`define IOPCED_OFF_IRQ_MASK 12'h028
// ****************************************
// field positions
// ****************************************
`define IOPCED_INST_LSB 0
`define IOPCED_SRC_BIT 3
`define IOPCED_TYPE_LSB 4
`define IOPCED_MODE_LSB 6
`define IOPCED_MULT_MSB 5
`define IOPCED_BASE_LSB 6
// ****************************************
// reset values and timing, periods in units of 0.1 ms, clock in MHz
// ****************************************
`define IOPCED_CTRL_RST 3'h0
`define IOPCED_CYCLE_RST 8'h00
`define IOPCED_MIN_TENTHS 11'h004
`define IOPCED_B01_OFS_TENTHS 11'h040
`define IOPCED_B01_STEP_TENTHS 11'h004
`define IOPCED_B10_OFS_TENTHS 11'h140
`define IOPCED_B10_STEP_TENTHS 11'h010
`define IOPCED_INST_APP 3'h4
`define IOPCED_PCLK_MHZ 125
`endif

/* File: core/iopced_pkg.sv */
package iopced_pkg;
    typedef enum logic [1:0] {
        IOPCED_BASE_100US,
        IOPCED_BASE_400US,
        IOPCED_BASE_1600US,
        IOPCED_BASE_RSVD
    } iopced_base_t;
    typedef enum logic [2:0] {
        IOPCED_VAL_NONE,
        IOPCED_VAL_V10,
        IOPCED_VAL_V11,
        IOPCED_VAL_V11_BACKUP,
        IOPCED_VAL_V11_RESTORE
    } iopced_valid_t;
endpackage : iopced_pkg

/* File: bench/iopced_checker.sv */
`timescale 1ns/1ps
// ****
// port checker
// ****
module iopced_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq,
    input wire logic [10:0] cycle_period_tenths,
    input wire logic [23:0] cycle_period_clocks,
    input wire logic id_check_en,
    input wire logic rev_v11,
    input wire logic offline_cfg_wr,
    input wire logic ds_backup_en,
    input wire logic ds_restore_en
);
    logic cyc_wr;
    assign cyc_wr = psel && penable && pwrite && paddr == 12'h004;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_rdy;
        psel && penable && !pready |=> pready;
    endproperty
    a_rdy: assert property (p_rdy) else $error("no answer after one wait state");
    property p_one;
        pready |=> !pready;
    endproperty
    a_one: assert property (p_one) else $error("pready longer than one cycle");
    property p_err;
        pslverr |-> pready;
    endproperty
    a_err: assert property (p_err) else $error("error without pready");
    property p_none;
        !id_check_en |-> !(rev_v11 || offline_cfg_wr || ds_backup_en || ds_restore_en);
    endproperty
    a_none: assert property (p_none) else $error("policy active without identity check");
    property p_off;
        offline_cfg_wr |-> id_check_en && !ds_restore_en && !ds_backup_en;
    endproperty
    a_off: assert property (p_off) else $error("offline write mixed with storage");
    property p_bkp;
        ds_backup_en |-> ds_restore_en && rev_v11 && id_check_en && !offline_cfg_wr;
    endproperty
    a_bkp: assert property (p_bkp) else $error("backup policy wrong");
    property p_rst;
        ds_restore_en && !ds_backup_en |-> rev_v11 && id_check_en && !offline_cfg_wr;
    endproperty
    a_rst: assert property (p_rst) else $error("restore-only policy wrong");
    property p_min;
        cycle_period_tenths >= 11'h004;
    endproperty
    a_min: assert property (p_min) else $error("period below minimum");
    property p_max;
        cycle_period_tenths <= 11'h530;
    endproperty
    a_max: assert property (p_max) else $error("period above maximum");
    property p_clk;
        $past(presetn) |-> cycle_period_clocks == $past(cycle_period_tenths) * 32'h000030D4;
    endproperty
    a_clk: assert property (p_clk) else $error("clock count disagrees with period");
    property p_chg;
        !$stable(cycle_period_tenths) |-> $past(cyc_wr) || $past(cyc_wr, 2);
    endproperty
    a_chg: assert property (p_chg) else $error("period changed without write");
    property p_rej;
        cyc_wr && !pready && pwdata[7:6] == 2'h3 |=> $stable(cycle_period_tenths) [*3];
    endproperty
    a_rej: assert property (p_rej) else $error("reserved base changed period");
    c_err: cover property (pslverr);
    c_irq: cover property (irq);
    c_bkp: cover property (ds_backup_en);
    c_max: cover property (cycle_period_tenths == 11'h530);
endmodule : iopced_checker
bind iopced_top iopced_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .pslverr, .irq, .cycle_period_tenths, .cycle_period_clocks, .id_check_en, .rev_v11, .offline_cfg_wr,
    .ds_backup_en, .ds_restore_en);

/* File: bench/iopced_dev_model.sv */
`timescale 1ns/1ps
// ****
// field device event source
// ****
module iopced_dev_model (
    input wire logic [2:0] ev_idx,
    output logic [23:0] rec
);
    logic [7:0] desc [8] = '{8'hD4, 8'h0B, 8'h68, 8'hB9, 8'h55, 8'h00, 8'h00, 8'h00};
    always_comb begin
        rec = {desc[ev_idx], 13'h1A00, ev_idx};
    end
endmodule : iopced_dev_model

/* File: bench/tb_top.sv */
`timescale 1ns/1ps
`include "iopced_map.svh"
module tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready, pslverr, irq, id_check_en, rev_v11, offline_cfg_wr, ds_backup_en, ds_restore_en;
    logic [10:0] cycle_period_tenths;
    logic [23:0] cycle_period_clocks;
    logic [23:0] rec;
    logic [2:0] ev_idx = 3'h0;
    logic [31:0] rd;
    logic err;
    logic [31:0] pol [5] = '{32'h00, 32'h05, 32'h07, 32'h1B, 32'h13};
    logic [7:0] cyc [8] = '{8'h00, 8'h02, 8'h3F, 8'h40, 8'h7F, 8'h80, 8'hBF, 8'hC5};
    logic [10:0] per [8] = '{11'h004, 11'h004, 11'h03F, 11'h040, 11'h13C, 11'h140, 11'h530, 11'h530};
    logic [31:0] fld [4] = '{32'h03010004, 32'h0404010B, 32'h01020100, 32'h02030109};
    int fail_count = 0;
    int n_compared = 0;
    always #4 pclk = ~pclk;
    iopced_top #(.EVT_DEPTH(4)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .irq, .cycle_period_tenths, .cycle_period_clocks, .id_check_en, .rev_v11,
        .offline_cfg_wr, .ds_backup_en, .ds_restore_en);
    iopced_dev_model dev (.ev_idx, .rec);
    // ****
    // tasks
    // ****
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run
    // one apb transfer, entered just after a rising edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            fail_count++;
            complete_run();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer
    task automatic rc(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h00000000);
        chk(rd, exp);
    endtask : rc
    // ****
    // main sequence
    // ****
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        rc(`IOPCED_OFF_CTRL, 32'h00000000);
        rc(`IOPCED_OFF_PERIOD, 32'h00000004);
        chk(cycle_period_clocks, 32'h0000C350);
        for (int i = 0; i < 5; i++) begin
            xfer(1'b1, `IOPCED_OFF_CTRL, 32'(i));
            rc(`IOPCED_OFF_POLICY, pol[i]);
            chk({ds_restore_en, ds_backup_en, offline_cfg_wr, rev_v11, id_check_en}, pol[i]);
        end
        xfer(1'b1, `IOPCED_OFF_CTRL, 32'h00000005);
        chk(err, 1'b1);
        for (int i = 0; i < 8; i++) begin
            xfer(1'b1, `IOPCED_OFF_CYCLE, {24'h000000, cyc[i]});
            chk(err, i == 7);
            chk(cycle_period_tenths, per[i]);
        end
        chk(cycle_period_clocks, 32'h00FD4BC0);
        xfer(1'b1, `IOPCED_OFF_IRQ_MASK, 32'h00000002);
        for (int i = 0; i < 5; i++) begin
            ev_idx <= 3'(i);
            @(posedge pclk);
            xfer(1'b1, `IOPCED_OFF_EVT_IN, {8'h00, rec});
        end
        rc(`IOPCED_OFF_EVT_CNT, 32'h00000004);
        chk(irq, 1'b1);
        rc(`IOPCED_OFF_IRQ_STAT, 32'h0000000F);
        xfer(1'b1, `IOPCED_OFF_IRQ_STAT, 32'h00000002);
        rc(`IOPCED_OFF_IRQ_STAT, 32'h0000000D);
        chk(irq, 1'b0);
        for (int i = 0; i < 5; i++) begin
            ev_idx <= 3'(i);
            @(posedge pclk);
            rc(`IOPCED_OFF_EVT_DESC, (i < 4) ? {8'h00, rec} : 32'h00000000);
            if (i < 4) begin
                rc(`IOPCED_OFF_EVT_FLD, fld[i]);
            end
            xfer(1'b1, `IOPCED_OFF_EVT_POP, 32'h00000000);
        end
        rc(`IOPCED_OFF_EVT_CNT, 32'h00000000);
        xfer(1'b0, 12'h03C, 32'h00000000);
        chk(err, 1'b1);
        complete_run();
    end
endmodule : tb_top
